// [hdl/acs_pkg.sv]
package acs_pkg;
    // Register indices, one aligned word each
    localparam logic [11:0] CTRL0_ADDR = 12'hF70;
    localparam logic [11:0] CTRL1_ADDR = 12'hF71;
    localparam logic [11:0] DATAH_ADDR = 12'hF72;
    localparam logic [11:0] DATAL_ADDR = 12'hF73;
    // Bus byte address is the register index shifted left by this amount
    localparam int ADDR_SHIFT = 2;
    // Control register 0 fields
    localparam int GO_BIT = 7;
    localparam int REFLO_BIT = 6;
    localparam int REFPIN_BIT = 5;
    localparam int REPEAT_BIT = 4;
    localparam int CHAN_MSB = 3;
    // Control/status register 1 fields
    localparam int REFHI_BIT = 7;
    localparam int PWRDN_BIT = 1;
    localparam int BUSY_BIT = 0;
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    localparam logic REFHI_RESET = 1'b1;
    // Timing, in system clock cycles
    localparam int IDLE_CYCLES = 160;
    localparam int PWRUP_CYCLES = 40;
    localparam int FIRST_CYCLES = 5129;
    localparam int NEXT_CYCLES = 256;
    localparam int RESULT_W = 13;
    localparam int CNT_W = 13;
    // Sequencer states, Gray along off -> powerup -> convert
    typedef enum logic [1:0] {
        ACS_OFF = 2'b00,
        ACS_PWRUP = 2'b01,
        ACS_CONV = 2'b11,
        ACS_IDLE = 2'b10
    } acs_state_e;
endpackage : acs_pkg

// [hdl/acs_apb_regs.sv]
`timescale 1ns/100ps
// APB slave: decodes words, zero wait states, error on unmapped address
module acs_apb_regs (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Access phase
    input wire logic pwrite, // Write direction
    input wire logic [13:0] paddr, // Byte address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [7:0] rd_ctrl0, // Live control 0 view
    input wire logic [7:0] rd_ctrl1, // Live control 1 view
    input wire logic [7:0] rd_datah, // Result high byte
    input wire logic [7:0] rd_datal, // Result low byte
    output logic [31:0] prdata, // Read data
    output logic pready, // Always ready
    output logic pslverr, // Unmapped access
    output logic wr_ctrl0, // Write strobe control 0
    output logic wr_ctrl1, // Write strobe control 1
    output logic [7:0] wr_data // Written byte
);
    logic [11:0] idx;
    logic hit;
    logic access;

    // Address to register index
    assign idx = paddr[13:acs_pkg::ADDR_SHIFT];
    assign hit = (idx == acs_pkg::CTRL0_ADDR) || (idx == acs_pkg::CTRL1_ADDR) ||
                 (idx == acs_pkg::DATAH_ADDR) || (idx == acs_pkg::DATAL_ADDR);
    assign access = psel && penable;
    assign pready = 1'b1;
    assign pslverr = access && !hit;
    assign wr_ctrl0 = access && pwrite && (idx == acs_pkg::CTRL0_ADDR);
    assign wr_ctrl1 = access && pwrite && (idx == acs_pkg::CTRL1_ADDR);
    assign wr_data = pwdata[7:0];

    // Read mux, upper bits zero
    always_comb begin
        prdata = 32'h0000_0000;
        if (idx == acs_pkg::CTRL0_ADDR) begin
            prdata[7:0] = rd_ctrl0;
        end else if (idx == acs_pkg::CTRL1_ADDR) begin
            prdata[7:0] = rd_ctrl1;
        end else if (idx == acs_pkg::DATAH_ADDR) begin
            prdata[7:0] = rd_datah;
        end else if (idx == acs_pkg::DATAL_ADDR) begin
            prdata[7:0] = rd_datal;
        end
    end
endmodule : acs_apb_regs

// [hdl/acs_sequencer.sv]
`timescale 1ns/100ps
module acs_sequencer #(
    parameter int IDLE_CYCLES = acs_pkg::IDLE_CYCLES, // Idle cycles before power-down
    parameter int PWRUP_CYCLES = acs_pkg::PWRUP_CYCLES, // Power-up cycles
    parameter int FIRST_CYCLES = acs_pkg::FIRST_CYCLES, // First conversion length
    parameter int NEXT_CYCLES = acs_pkg::NEXT_CYCLES // Continuous result interval
) (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [13:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic conv_enable, // Completion request enabled by system; conversions run regardless
    input wire logic [12:0] filter_data, // Raw result from decimation filter
    output logic [7:0] input_channel_select, // Analog mux select
    output logic [1:0] ref_level, // {hi, lo} reference select
    output logic ref_to_pin, // Buffer reference onto pin
    output logic modulator_power, // Modulator powered
    output logic filter_restart, // Restart filter at conversion start
    output logic conv_irq // Conversion complete request, one cycle
);
    localparam logic [acs_pkg::CNT_W-1:0] IDLE_LAST = acs_pkg::CNT_W'(IDLE_CYCLES - 1);
    localparam logic [acs_pkg::CNT_W-1:0] PWRUP_LAST = acs_pkg::CNT_W'(PWRUP_CYCLES - 1);
    localparam logic [acs_pkg::CNT_W-1:0] FIRST_LAST = acs_pkg::CNT_W'(FIRST_CYCLES - 1);
    localparam logic [acs_pkg::CNT_W-1:0] NEXT_LAST = acs_pkg::CNT_W'(NEXT_CYCLES - 1);

    acs_pkg::acs_state_e state;
    logic [7:0] ctrl0;
    logic ref_level_hi_bit;
    logic [acs_pkg::CNT_W-1:0] cnt;
    logic [acs_pkg::CNT_W-1:0] idle_cnt;
    logic first_done;
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
    logic wr_ctrl0;
    logic wr_ctrl1;
    logic [7:0] wr_data;
    logic go_write;
    logic conv_done;
    logic conversion_go;
    logic repeat_select;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus slave

    acs_apb_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .rd_ctrl0(ctrl0),
        .rd_ctrl1({ref_level_hi_bit, 5'h00, state == acs_pkg::ACS_OFF, state != acs_pkg::ACS_IDLE &&
                   state != acs_pkg::ACS_OFF}),
        .rd_datah(result_high_byte),
        .rd_datal(result_low_byte),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .wr_ctrl0(wr_ctrl0),
        .wr_ctrl1(wr_ctrl1),
        .wr_data(wr_data)
    );

    assign conversion_go = ctrl0[acs_pkg::GO_BIT];
    assign repeat_select = ctrl0[acs_pkg::REPEAT_BIT];
    assign go_write = wr_ctrl0 && wr_data[acs_pkg::GO_BIT];
    assign conv_done = (state == acs_pkg::ACS_CONV) && !go_write &&
                       (cnt == (first_done ? NEXT_LAST : FIRST_LAST));

    ////////////////////////////////////////////////////////////////////////////
    // Control register 0: bits 6:0 at once, go set by writing one, cleared by hardware

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0 <= acs_pkg::CTRL0_RESET;
        end else begin
            if (wr_ctrl0) begin
                ctrl0[6:0] <= wr_data[6:0];
            end
            if (go_write) begin
                ctrl0[acs_pkg::GO_BIT] <= 1'b1;
            end else if (conv_done) begin
                ctrl0[acs_pkg::GO_BIT] <= 1'b0;
            end
        end
    end

    // Control/status register 1: reference high bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_level_hi_bit <= acs_pkg::REFHI_RESET;
        end else if (wr_ctrl1) begin
            ref_level_hi_bit <= wr_data[acs_pkg::REFHI_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: power-up, first conversion, repeat interval

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= acs_pkg::ACS_OFF;
            cnt <= '0;
            first_done <= 1'b0;
        end else if (go_write) begin
            cnt <= '0;
            first_done <= 1'b0;
            if (state == acs_pkg::ACS_OFF || state == acs_pkg::ACS_PWRUP) begin
                state <= acs_pkg::ACS_PWRUP;
            end else begin
                state <= acs_pkg::ACS_CONV;
            end
        end else begin
            case (state)
                acs_pkg::ACS_OFF: begin
                    cnt <= '0;
                end
                acs_pkg::ACS_PWRUP: begin
                    if (cnt == PWRUP_LAST) begin
                        cnt <= '0;
                        state <= acs_pkg::ACS_CONV;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                acs_pkg::ACS_CONV: begin
                    if (conv_done) begin
                        cnt <= '0;
                        first_done <= 1'b1;
                        if (!repeat_select) begin
                            state <= acs_pkg::ACS_IDLE;
                        end
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                acs_pkg::ACS_IDLE: begin
                    cnt <= '0;
                    if (idle_cnt == IDLE_LAST) begin
                        state <= acs_pkg::ACS_OFF;
                    end
                end
                default: begin
                    state <= acs_pkg::ACS_OFF;
                    cnt <= '0;
                end
            endcase
        end
    end

    // Idle counter, restarts on start or completion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_cnt <= '0;
        end else if (go_write || conv_done || state != acs_pkg::ACS_IDLE) begin
            idle_cnt <= '0;
        end else if (idle_cnt != IDLE_LAST) begin
            idle_cnt <= idle_cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result capture and completion request

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_high_byte <= 8'h00;
            result_low_byte <= 8'h00;
        end else if (conv_done) begin
            result_high_byte <= filter_data[12:5];
            result_low_byte <= {filter_data[4:0], 3'h0};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_irq <= 1'b0;
        end else begin
            conv_irq <= conv_done && conv_enable;
        end
    end

    // Analog side controls
    always_comb begin
        input_channel_select = 8'h00;
        if (!ctrl0[acs_pkg::CHAN_MSB]) begin
            input_channel_select[ctrl0[2:0]] = 1'b1;
        end
    end
    assign ref_level = {ref_level_hi_bit, ctrl0[acs_pkg::REFLO_BIT]};
    assign ref_to_pin = ctrl0[acs_pkg::REFPIN_BIT];
    assign modulator_power = (state != acs_pkg::ACS_OFF);
    assign filter_restart = go_write;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    power_down_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == acs_pkg::ACS_IDLE && idle_cnt == IDLE_LAST && !go_write |=> state == acs_pkg::ACS_OFF)
        else $error("power-down missed after idle");
    power_up_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == acs_pkg::ACS_OFF && go_write |=> state == acs_pkg::ACS_PWRUP)
        else $error("request did not wake converter");
    pwrup_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state == acs_pkg::ACS_PWRUP) && cnt == 0 |-> ##PWRUP_CYCLES (state == acs_pkg::ACS_CONV || go_write))
        else $error("power-up length wrong");
    go_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done |=> !conversion_go || $past(go_write))
        else $error("go not cleared at completion");
    single_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done && !repeat_select |=> state == acs_pkg::ACS_IDLE)
        else $error("single-shot did not stop");
    repeat_period_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done && repeat_select && !wr_ctrl0 |-> ##1 (!conv_done)[*8])
        else $error("repeat result too early");
    irq_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done && conv_enable |=> conv_irq ##1 !conv_irq)
        else $error("completion request missing");
    irq_disabled_a: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(conv_enable) |-> !conv_irq)
        else $error("request while disabled");
    result_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_done |=> result_high_byte == $past(filter_data[12:5]))
        else $error("result not stored");
endmodule : acs_sequencer

// [dv/acs_filter_model.sv]
`timescale 1ns/100ps
// Decimation filter stand-in: shows the bench's sample only while the modulator is powered
module acs_filter_model (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic modulator_power, // Modulator powered
    input wire logic filter_restart, // Restart pulse, accepted only
    input wire logic [12:0] sample_val, // Value the bench wants converted
    output logic [12:0] filter_data // Raw result to the sequencer
);
    logic [12:0] last;
    // Remember the last valid output so a dead filter cannot look valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last <= 13'h0000;
        end else if (modulator_power) begin
            last <= sample_val;
        end
    end
    // Unpowered filter drives the inverse of its last value
    assign filter_data = modulator_power ? sample_val : ~last;
endmodule : acs_filter_model

// [dv/adc_conversion_sequencer_tb.sv]
`timescale 1ns/100ps
module adc_conversion_sequencer_tb;
    localparam int IDL = 8;
    localparam int PWU = 4;
    localparam int FST = 20;
    localparam int NXT = 12;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, conv_enable = 1'b1;
    logic [13:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [12:0] sample_val = 13'h0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, ref_to_pin, modulator_power, filter_restart, conv_irq;
    logic [7:0] input_channel_select;
    logic [1:0] ref_level;
    logic [12:0] filter_data;
    int err_total = 0, compares = 0, cyc = 0, t_wr = 0, n_rst = 0;
    ////////////////////////////////////////////////////////////////
    // Clock and cycle count
    always #20 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    // Count filter restart pulses seen at clock edges
    always @(posedge pclk) if (filter_restart === 1'b1) n_rst <= n_rst + 1;
    acs_sequencer #(.IDLE_CYCLES(IDL), .PWRUP_CYCLES(PWU), .FIRST_CYCLES(FST), .NEXT_CYCLES(NXT)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_enable(conv_enable),
        .filter_data(filter_data), .input_channel_select(input_channel_select), .ref_level(ref_level),
        .ref_to_pin(ref_to_pin), .modulator_power(modulator_power), .filter_restart(filter_restart),
        .conv_irq(conv_irq));
    acs_filter_model flt_u (.pclk(pclk), .presetn(presetn), .modulator_power(modulator_power),
        .filter_restart(filter_restart), .sample_val(sample_val), .filter_data(filter_data));
    ////////////////////////////////////////////////////////////////
    // Shared tasks
    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    // APB transfer; write moment recorded for latency counts
    task apb(input logic wr, input logic [11:0] idx, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        if (wr) t_wr = cyc + 1;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let the write land before the caller looks at outputs
        @(posedge pclk);
    endtask : apb
    // Wait for the completion request, compare its delay and width
    task wait_irq(input int ex);
        int n;
        n = 0;
        while (conv_irq !== 1'b1 && n < 9000) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk("irq latency", 32'(ex), 32'(cyc - t_wr));
        t_wr = cyc;
        @(posedge pclk);
        #1;
        chk("irq width", 32'h0, {31'h0, conv_irq});
    endtask : wait_irq
    task quiet(input int n);
        int h;
        h = 0;
        repeat (n) begin
            @(posedge pclk);
            #1;
            if (conv_irq !== 1'b0) h++;
        end
        chk("stray irq", 32'h0, 32'(h));
    endtask : quiet
    ////////////////////////////////////////////////////////////////
    // Scenarios
    task t_reset;
        chk("power at reset", 32'h0, {31'h0, modulator_power});
        chk("ref default", 32'h2, {30'h0, ref_level});
        apb(1'b0, acs_pkg::CTRL0_ADDR, 8'h00);
        chk("ctrl0 reset", 32'h0, rd);
        apb(1'b0, acs_pkg::CTRL1_ADDR, 8'h00);
        chk("ctrl1 flags", 32'h6, {29'h0, rd[7], rd[1:0]});
        apb(1'b0, acs_pkg::DATAH_ADDR, 8'h00);
        chk("datah reset", 32'h0, rd);
        apb(1'b0, 12'hF7F, 8'h00);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        $display("test reset done");
    endtask : t_reset
    task t_fields;
        logic [3:0] c;
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            apb(1'b1, acs_pkg::CTRL0_ADDR, {1'b0, c[0], c[1], 1'b0, c});
            chk("channel", (c < 8) ? 32'h1 << c : 32'h0, {24'h0, input_channel_select});
            chk("ref pin", {31'h0, c[1]}, {31'h0, ref_to_pin});
            chk("ref lo", {31'h0, c[0]}, {31'h0, ref_level[0]});
        end
        chk("no start", 32'h0, {31'h0, modulator_power});
        for (int j = 0; j < 3; j++) begin
            c = 4'(j);
            apb(1'b1, acs_pkg::CTRL1_ADDR, {c[1], 7'h00});
            apb(1'b1, acs_pkg::CTRL0_ADDR, {1'b0, c[0], 6'h00});
            chk("ref code", {30'h0, c[1:0]}, {30'h0, ref_level});
        end
        $display("test fields done");
    endtask : t_fields
    task t_single;
        sample_val <= 13'h1A5B;
        apb(1'b1, acs_pkg::CTRL0_ADDR, 8'h83);
        chk("restart pulse", 32'h1, 32'(n_rst));
        apb(1'b0, acs_pkg::CTRL0_ADDR, 8'h00);
        chk("go busy", 32'h1, {31'h0, rd[7]});
        wait_irq(PWU + FST);
        quiet(IDL - 5);
        chk("power idle", 32'h1, {31'h0, modulator_power});
        quiet(6);
        chk("power down", 32'h0, {31'h0, modulator_power});
        apb(1'b0, acs_pkg::CTRL0_ADDR, 8'h00);
        chk("go clear", 32'h0, {31'h0, rd[7]});
        apb(1'b0, acs_pkg::DATAH_ADDR, 8'h00);
        chk("datah", {24'h0, sample_val[12:5]}, rd);
        apb(1'b0, acs_pkg::DATAL_ADDR, 8'h00);
        chk("datal", {24'h0, sample_val[4:0], 3'h0}, rd);
        $display("test single done");
    endtask : t_single
    task t_restart;
        apb(1'b1, acs_pkg::CTRL0_ADDR, 8'h80);
        quiet(PWU + 5);
        chk("power conv", 32'h1, {31'h0, modulator_power});
        apb(1'b1, acs_pkg::CTRL0_ADDR, 8'h00);
        apb(1'b0, acs_pkg::CTRL0_ADDR, 8'h00);
        chk("go kept", 32'h1, {31'h0, rd[7]});
        apb(1'b1, acs_pkg::CTRL0_ADDR, 8'h80);
        wait_irq(FST);
        apb(1'b1, acs_pkg::CTRL0_ADDR, 8'h80);
        wait_irq(FST);
        $display("test restart done");
    endtask : t_restart
    task t_repeat_select;
        quiet(IDL + 4);
        sample_val <= 13'h0F0F;
        apb(1'b1, acs_pkg::CTRL0_ADDR, 8'h95);
        wait_irq(PWU + FST);
        @(posedge pclk) sample_val <= 13'h1234;
        apb(1'b0, acs_pkg::CTRL0_ADDR, 8'h00);
        chk("go first", 32'h0, {31'h0, rd[7]});
        wait_irq(NXT);
        apb(1'b0, acs_pkg::DATAH_ADDR, 8'h00);
        chk("datah next", {24'h0, sample_val[12:5]}, rd);
        sample_val <= 13'h0AAA;
        conv_enable <= 1'b0;
        quiet(NXT + 2);
        apb(1'b1, acs_pkg::CTRL0_ADDR, 8'h05);
        quiet(NXT);
        apb(1'b0, acs_pkg::DATAH_ADDR, 8'h00);
        chk("datah masked", {24'h0, sample_val[12:5]}, rd);
        conv_enable <= 1'b1;
        apb(1'b0, acs_pkg::CTRL1_ADDR, 8'h00);
        chk("stopped", 32'h2, {30'h0, rd[1:0]});
        quiet(2 * NXT);
        $display("test continuous done");
    endtask : t_repeat_select
    ////////////////////////////////////////////////////////////////
    // Verdict and sequence
    task results;
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    initial begin
        repeat (2000) @(posedge pclk);
        err_total++;
        $display("MISMATCH watchdog expected done seen timeout");
        results;
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_fields;
        t_single;
        t_restart;
        t_repeat_select;
        results;
    end
endmodule : adc_conversion_sequencer_tb
